//--- rtl/qsw_consts.svh
/*
  constants for the quad switch control block: frame layout, timing, reset values.
  assumes the includer compiles it once per unit; guarded against double inclusion.
*/
`ifndef QSW_CONSTS_SVH
`define QSW_CONSTS_SVH

`define QSW_NUM_CH          4
`define QSW_FRAME_BITS      8
`define QSW_BIT_CNT_W       4
`define QSW_FRAME_CMD_LSB   0
`define QSW_FRAME_CMD_MSB   3
`define QSW_FRAME_CHK_LSB   4
`define QSW_FRAME_CHK_MSB   7
`define QSW_SNAP_REV_LSB    0
`define QSW_SNAP_FLT_LSB    4
`define QSW_SYS_CLK_KHZ     20000
`define QSW_BOOST_MIN_MS    10
`define QSW_BOOST_CYCLES    (`QSW_BOOST_MIN_MS * `QSW_SYS_CLK_KHZ)
`define QSW_BOOST_CNT_W     18
`define QSW_CMD_RST         4'h0
`define QSW_SNAP_RST        8'h00

`endif

//--- rtl/qsw_pkg.sv
/*
  types shared by the quad switch control block.
  assumes qsw_consts.svh is on the include path.
*/
`default_nettype none
`include "qsw_consts.svh"

package qsw_pkg;

  typedef enum logic [1:0] {
    QSW_BST_IDLE = 2'b01,
    QSW_BST_RUN  = 2'b10
  } qsw_boost_e;

  // analog monitor flags, all active high
  typedef struct packed {
    logic                       chip_hot;
    logic [`QSW_NUM_CH-1:0]     ch_hot;
    logic [`QSW_NUM_CH-1:0]     ch_reverse;
    logic                       v5_low;
    logic                       any_supply_low;
    logic                       limit_short;
  } qsw_mon_s;

  typedef struct packed {
    logic                       cs_n;
    logic [`QSW_NUM_CH-1:0]     ch_cmd;
    logic                       hold;
    logic                       fast;
    logic                       boost;
    logic                       off_n;
    logic                       serial_variant;
    qsw_mon_s                   mon;
  } qsw_pins_s;

  typedef struct packed {
    qsw_pins_s                  s1;
    qsw_pins_s                  s2;
    logic                       tgl_s1;
    logic                       tgl_s2;
    logic                       tgl_seen;
    logic                       cs_n_d;
    logic [`QSW_NUM_CH-1:0]     held_cmd;
    logic [`QSW_NUM_CH-1:0]     ser_cmd;
    logic [`QSW_NUM_CH-1:0]     sw_on;
    logic [`QSW_FRAME_BITS-1:0] snap;
    qsw_boost_e                 bst;
    logic [`QSW_BOOST_CNT_W-1:0] bst_cnt;
    logic                       boost_act;
    logic                       fast_edge;
    logic                       fault_oe;
    logic                       rev_oe;
    logic                       link_err_oe;
    logic                       sdo_oe;
  } qsw_state_s;

endpackage

`default_nettype wire

//--- rtl/qsw_serial_link.sv
/*
  serial link end: shifts frames in on the serial clock and status out.
  assumes sclk stands still while chip select is high; chip select high clears the frame.
*/
`default_nettype none
`include "qsw_consts.svh"

module qsw_serial_link (
  input  wire logic                       sclk,
  input  wire logic                       rst_n,
  input  wire logic                       cs_n,
  input  wire logic                       sdi,
  input  wire logic [`QSW_FRAME_BITS-1:0] snap,
  output logic      [`QSW_FRAME_BITS-1:0] frame_word,
  output logic                            frame_tgl,
  output logic                            sdo
);

  logic [`QSW_FRAME_BITS-2:0] rx_ff;
  logic [`QSW_BIT_CNT_W-1:0]  bcnt_ff;
  logic [`QSW_BIT_CNT_W-1:0]  ocnt_ff;
  logic [`QSW_FRAME_BITS-1:0] word_ff;
  logic                       tgl_ff;

  // frame state cleared by chip select high, so a cut frame never leaks on
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      rx_ff   <= '0;
      bcnt_ff <= '0;
    end else begin
      rx_ff   <= {rx_ff[`QSW_FRAME_BITS-3:0], sdi};
      if (bcnt_ff == `QSW_BIT_CNT_W'(`QSW_FRAME_BITS - 1)) begin
        bcnt_ff <= '0;
      end else begin
        bcnt_ff <= bcnt_ff + `QSW_BIT_CNT_W'(1);
      end
    end
  end

  // word is held until the next full frame, so the other domain reads it stable
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      word_ff <= `QSW_SNAP_RST;
      tgl_ff  <= 1'b0;
    end else if (!cs_n && bcnt_ff == `QSW_BIT_CNT_W'(`QSW_FRAME_BITS - 1)) begin
      word_ff <= {rx_ff, sdi};
      tgl_ff  <= ~tgl_ff;
    end
  end

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      ocnt_ff <= '0;
    end else if (ocnt_ff != `QSW_BIT_CNT_W'(`QSW_FRAME_BITS - 1)) begin
      ocnt_ff <= ocnt_ff + `QSW_BIT_CNT_W'(1);
    end
  end

  assign sdo        = snap[3'(`QSW_FRAME_BITS - 1) - ocnt_ff[2:0]];
  assign frame_word = word_ff;
  assign frame_tgl  = tgl_ff;

endmodule

`default_nettype wire

//--- rtl/qsw_ctrl.sv
/*
  control and status pin logic of a quad low-side switch: serial or parallel
  channel command, global off, supply and thermal shutdown, inrush boost timer,
  open-drain fault, reverse and serial-error outputs.
  assumes pins and monitor flags are asynchronous to sys_clk; pull resistors on
  undriven pins and the analog switch drivers live outside this logic.

// Contract
// - chip select low latches status, enables link
// - serial input sampled on rising clock
// - serial output changes on falling clock
// - serial output released while select high
// - corrupted serial frame pulls link error low
// - hold low: channel inputs pass through
// - hold high: channel inputs captured, frozen
// - edge select high fast, low slow
// - boost doubles limit 10ms after turn-on
// - global off low forces all switches off
// - fault output low on any fault
// - reverse gate low on any reverse current
// - undriven select high, others low
// - fault sources: heat, reverse, v5, limit short
// - supply undervoltage holds all switches off
*/
`default_nettype none
`include "qsw_consts.svh"

module qsw_ctrl #(
  parameter int BOOST_CYCLES = `QSW_BOOST_CYCLES
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst_b,
  input  wire logic                   clk_en,
  input  wire logic                   sclk,
  input  wire logic                   cs_n,
  input  wire logic                   sdi,
  input  wire logic [`QSW_NUM_CH-1:0] channel_command,
  input  wire logic                   input_hold_control,
  input  wire logic                   fast_edge_select,
  input  wire logic                   boost_enable,
  input  wire logic                   global_off_n,
  input  wire logic                   serial_variant,
  input  wire qsw_pkg::qsw_mon_s      monitor,
  output logic                        sdo,
  output logic                        sdo_oe,
  output logic [`QSW_NUM_CH-1:0]      switch_on,
  output logic                        fast_edge,
  output logic                        boost_active,
  output logic                        fault_n_o,
  output logic                        fault_n_oe,
  output logic                        reverse_gate_drive_n_o,
  output logic                        reverse_gate_drive_n_oe,
  output logic                        serial_link_error_n_o,
  output logic                        serial_link_error_n_oe
);

  logic [1:0]                 rst_sync_ff;
  logic                       rst_n;
  qsw_pkg::qsw_state_s        st_ff;
  qsw_pkg::qsw_state_s        nxt_st;
  qsw_pkg::qsw_pins_s         pins;
  logic [`QSW_FRAME_BITS-1:0] frame_word;
  logic                       frame_tgl;

  function automatic logic frame_ok(input logic [`QSW_FRAME_BITS-1:0] w);
    frame_ok = (w[`QSW_FRAME_CHK_MSB:`QSW_FRAME_CHK_LSB]
               == ~w[`QSW_FRAME_CMD_MSB:`QSW_FRAME_CMD_LSB]);
  endfunction

  // reset released through two flops; assertion stays asynchronous
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  always_comb begin
    pins.cs_n           = cs_n;
    pins.ch_cmd         = channel_command;
    pins.hold           = input_hold_control;
    pins.fast           = fast_edge_select;
    pins.boost          = boost_enable;
    pins.off_n          = global_off_n;
    pins.serial_variant = serial_variant;
    pins.mon            = monitor;
  end

  qsw_serial_link u_link (
    .sclk       (sclk),
    .rst_n      (rst_n),
    .cs_n       (cs_n),
    .sdi        (sdi),
    .snap       (st_ff.snap),
    .frame_word (frame_word),
    .frame_tgl  (frame_tgl),
    .sdo        (sdo)
  );

  always_comb begin
    logic [`QSW_NUM_CH-1:0] cmd;
    logic [`QSW_NUM_CH-1:0] allow;
    logic                   chip_off;
    logic                   new_frame;
    cmd       = '0;
    allow     = '0;
    chip_off  = 1'b0;
    new_frame = 1'b0;
    nxt_st    = st_ff;

    // first stage feeds only the second
    nxt_st.s1     = pins;
    nxt_st.s2     = st_ff.s1;
    nxt_st.tgl_s1 = frame_tgl;
    nxt_st.tgl_s2 = st_ff.tgl_s1;
    nxt_st.cs_n_d = st_ff.s2.cs_n;

    // status snapshot taken at select fall; host must wait three sys_clk before sclk
    if (st_ff.cs_n_d && !st_ff.s2.cs_n) begin
      nxt_st.snap[`QSW_SNAP_FLT_LSB +: `QSW_NUM_CH] = st_ff.s2.mon.ch_hot;
      nxt_st.snap[`QSW_SNAP_REV_LSB +: `QSW_NUM_CH] = st_ff.s2.mon.ch_reverse;
    end
    nxt_st.sdo_oe = ~st_ff.s2.cs_n;

    // word is stable once the synced toggle shows a change
    new_frame       = (st_ff.tgl_s2 != st_ff.tgl_seen);
    nxt_st.tgl_seen = st_ff.tgl_s2;
    if (new_frame && st_ff.s2.serial_variant) begin
      if (frame_ok(frame_word)) begin
        nxt_st.ser_cmd     = frame_word[`QSW_FRAME_CMD_MSB:`QSW_FRAME_CMD_LSB];
        nxt_st.link_err_oe = 1'b0;
      end else begin
        nxt_st.link_err_oe = 1'b1;
      end
    end

    // hold copy follows while low and freezes once high
    if (!st_ff.s2.hold) begin
      nxt_st.held_cmd = st_ff.s2.ch_cmd;
    end
    if (st_ff.s2.serial_variant) begin
      cmd = st_ff.ser_cmd;
    end else if (st_ff.s2.hold) begin
      cmd = st_ff.held_cmd;
    end else begin
      cmd = st_ff.s2.ch_cmd;
    end

    chip_off = st_ff.s2.mon.chip_hot | st_ff.s2.mon.any_supply_low
             | st_ff.s2.mon.limit_short | ~st_ff.s2.off_n;
    allow    = ~st_ff.s2.mon.ch_hot & {`QSW_NUM_CH{~chip_off}};
    nxt_st.sw_on = cmd & allow;

    nxt_st.fast_edge = st_ff.s2.fast;

    // timer restarts on every turn-on so the boost spans the latest inrush
    case (st_ff.bst)
      qsw_pkg::QSW_BST_IDLE: begin
        if (st_ff.s2.boost && |(nxt_st.sw_on & ~st_ff.sw_on)) begin
          nxt_st.bst     = qsw_pkg::QSW_BST_RUN;
          nxt_st.bst_cnt = '0;
        end
      end
      qsw_pkg::QSW_BST_RUN: begin
        if (!st_ff.s2.boost) begin
          nxt_st.bst = qsw_pkg::QSW_BST_IDLE;
        end else if (|(nxt_st.sw_on & ~st_ff.sw_on)) begin
          nxt_st.bst_cnt = '0;
        end else if (st_ff.bst_cnt == `QSW_BOOST_CNT_W'(BOOST_CYCLES - 1)) begin
          nxt_st.bst = qsw_pkg::QSW_BST_IDLE;
        end else begin
          nxt_st.bst_cnt = st_ff.bst_cnt + `QSW_BOOST_CNT_W'(1);
        end
      end
      default: begin
        nxt_st.bst = qsw_pkg::QSW_BST_IDLE;
      end
    endcase
    nxt_st.boost_act = (nxt_st.bst == qsw_pkg::QSW_BST_RUN) && st_ff.s2.boost;

    nxt_st.fault_oe = st_ff.s2.mon.chip_hot
                    // commanded state, so a switch shut by its own heat keeps reporting
                    | (|(st_ff.s2.mon.ch_hot & cmd))
                    | (|st_ff.s2.mon.ch_reverse)
                    | st_ff.s2.mon.v5_low
                    | st_ff.s2.mon.limit_short;
    nxt_st.rev_oe   = |st_ff.s2.mon.ch_reverse;
  end

  // reset values match undriven pins: select high, all else low except v5_low and fault_oe, which reset high, and bst, which resets to QSW_BST_IDLE
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff                <= '0;
      st_ff.s1.cs_n        <= 1'b1;
      st_ff.s2.cs_n        <= 1'b1;
      st_ff.cs_n_d         <= 1'b1;
      st_ff.s1.mon.v5_low  <= 1'b1;
      st_ff.s2.mon.v5_low  <= 1'b1;
      st_ff.fault_oe       <= 1'b1;
      st_ff.held_cmd       <= `QSW_CMD_RST;
      st_ff.ser_cmd        <= `QSW_CMD_RST;
      st_ff.snap           <= `QSW_SNAP_RST;
      st_ff.bst            <= qsw_pkg::QSW_BST_IDLE;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign switch_on               = st_ff.sw_on;
  assign fast_edge               = st_ff.fast_edge;
  assign boost_active            = st_ff.boost_act;
  assign sdo_oe                  = st_ff.sdo_oe;
  assign fault_n_o               = 1'b0;
  assign fault_n_oe              = st_ff.fault_oe;
  assign reverse_gate_drive_n_o  = 1'b0;
  assign reverse_gate_drive_n_oe = st_ff.rev_oe;
  assign serial_link_error_n_o   = 1'b0;
  assign serial_link_error_n_oe  = st_ff.link_err_oe;

endmodule

`default_nettype wire

//--- bench/qsw_ctrl_checker.sv
/*
  concurrent checks on the quad switch control pins.
  checks pause while clk_en is low; bound into qsw_ctrl below.
*/
`default_nettype none
`include "qsw_consts.svh"
module qsw_ctrl_checker (
  input wire logic                   sys_clk,
  input wire logic                   rst_b,
  input wire logic                   clk_en,
  input wire logic                   cs_n,
  input wire logic [`QSW_NUM_CH-1:0] channel_command,
  input wire logic                   input_hold_control,
  input wire logic                   fast_edge_select,
  input wire logic                   boost_enable,
  input wire logic                   global_off_n,
  input wire logic                   serial_variant,
  input wire qsw_pkg::qsw_mon_s      monitor,
  input wire logic                   sdo_oe,
  input wire logic [`QSW_NUM_CH-1:0] switch_on,
  input wire logic                   fast_edge,
  input wire logic                   boost_active,
  input wire logic                   fault_n_oe,
  input wire logic                   reverse_gate_drive_n_oe
);
  default clocking dcb @(posedge sys_clk); endclocking
  default disable iff (!rst_b || !clk_en);
  wire logic quiet;
  assign quiet = global_off_n && !serial_variant && monitor == '0;
  // five samples cover two sync stages plus the output register
  sequence s_open;
    (quiet && !input_hold_control && $stable(channel_command))[*5];
  endsequence
  sequence s_held;
    (quiet && input_hold_control)[*6];
  endsequence
  a_pass_through: assert property (s_open |-> switch_on == channel_command)
    else $error("switch state does not follow channel inputs");
  a_hold_freeze: assert property (s_held |-> $stable(switch_on))
    else $error("switch state moved while inputs held");
  a_off_all: assert property ((!global_off_n)[*4] |-> switch_on == '0)
    else $error("switch on while global off low");
  a_supply_off: assert property (monitor.any_supply_low[*4] |-> switch_on == '0)
    else $error("switch on during supply lockout");
  a_edge_rate: assert property (($stable(fast_edge_select))[*4]
    |-> fast_edge == fast_edge_select) else $error("edge rate not following select");
  a_rev_gate: assert property (($stable(|monitor.ch_reverse))[*4]
    |-> reverse_gate_drive_n_oe == |monitor.ch_reverse) else $error("reverse gate wrong");
  a_fault_any: assert property ((monitor.chip_hot || monitor.v5_low
    || monitor.limit_short || |monitor.ch_reverse)[*4] |-> fault_n_oe)
    else $error("fault output not pulled on fault");
  a_boost_cause: assert property ($rose(boost_active)
    |-> (switch_on & ~$past(switch_on)) != '0) else $error("boost without turn-on");
  a_boost_off: assert property ((!boost_enable)[*4] |-> !boost_active)
    else $error("boost active while disabled");
  a_sdo_idle: assert property (cs_n[*4] |-> !sdo_oe)
    else $error("serial output driven while deselected");
endmodule
bind qsw_ctrl qsw_ctrl_checker u_chk (.sys_clk(sys_clk), .rst_b(rst_b), .cs_n(cs_n),
  .channel_command(channel_command), .input_hold_control(input_hold_control),
  .fast_edge_select(fast_edge_select), .boost_enable(boost_enable),
  .global_off_n(global_off_n), .serial_variant(serial_variant), .monitor(monitor),
  .sdo_oe(sdo_oe), .switch_on(switch_on), .fast_edge(fast_edge), .boost_active(boost_active),
  .fault_n_oe(fault_n_oe), .clk_en(clk_en), .reverse_gate_drive_n_oe(reverse_gate_drive_n_oe));
`default_nettype wire

//--- bench/qsw_host_model.sv
/*
  host side of the serial link: sends one frame, reads status back.
  assumes sdo_pin already resolves the pulldown when released.
*/
`default_nettype none
module qsw_host_model (
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  // clock only moves inside a frame
  task automatic xfer(input logic [7:0] w, input int half, output logic [7:0] rd);
    cs_n = 1'b0;
    #263;
    for (int i = 7; i >= 0; i--) begin
      sdi = w[i];
      #(half);
      sclk = 1'b1;
      rd[i] = sdo_pin;
      #(half);
      sclk = 1'b0;
    end
    #(half);
    cs_n = 1'b1;
    sdi = 1'b0;
    #320;
  endtask
endmodule
`default_nettype wire

//--- bench/test_qsw_ctrl.sv
/*
  self-checking bench for qsw_ctrl: parallel, hold, rates, faults, boost, serial.
  assumes the host model and checker are compiled first.
*/
`default_nettype none
module test_qsw_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BOOST = 20;
  logic              sys_clk, rst_b, hold, fast, boost, off_n, ser, en;
  logic [3:0]        cmd;
  logic [7:0]        rd;
  qsw_pkg::qsw_mon_s mon;
  wire logic         sclk, cs_n, sdi, sdo, sdo_oe, sdo_pin, fe, ba;
  wire logic         f_o, f_oe, r_o, r_oe, e_o, e_oe;
  wire logic [3:0]   sw;
  int                miscompares, checks_done, m_cmd, q[$];
  assign sdo_pin = sdo_oe ? sdo : 1'b0;
  qsw_ctrl #(.BOOST_CYCLES(BOOST)) dut (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(en),
    .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .channel_command(cmd), .input_hold_control(hold),
    .fast_edge_select(fast), .boost_enable(boost), .global_off_n(off_n),
    .serial_variant(ser), .monitor(mon), .sdo(sdo), .sdo_oe(sdo_oe), .switch_on(sw),
    .fast_edge(fe), .boost_active(ba), .fault_n_o(f_o), .fault_n_oe(f_oe),
    .reverse_gate_drive_n_o(r_o), .reverse_gate_drive_n_oe(r_oe),
    .serial_link_error_n_o(e_o), .serial_link_error_n_oe(e_oe));
  qsw_host_model host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo_pin(sdo_pin));
  always #25 sys_clk = ~sys_clk;
  task automatic chk(input string n, input int e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", n, e, g);
      miscompares++;
    end
  endtask
  function automatic logic [7:0] obs(input int k);
    case (k)
      0: obs = {4'h0, sw};
      1: obs = {7'h00, f_oe};
      2: obs = {7'h00, r_oe};
      3: obs = {7'h00, e_oe};
      4: obs = {7'h00, ba};
      default: obs = {7'h00, fe};
    endcase
  endfunction
  task automatic wt(input string n, input int k, input int e);
    @(negedge sys_clk);
    for (int i = 0; i < 40 && obs(k) !== e; i++) @(negedge sys_clk);
    chk(n, e, obs(k));
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #1ms;
    miscompares++;
    stop_test();
  end
  initial begin
    sys_clk = 1'b0;
    rst_b = 1'b0;
    {hold, fast, boost, off_n, ser, cmd, mon} = '0;
    en = 1'b1;
    miscompares = 0;
    checks_done = 0;
    m_cmd = $urandom(88928);
    repeat (5) @(negedge sys_clk);
    rst_b = 1'b1;
    off_n = 1'b1;
    for (int i = 0; i < 6; i++) begin
      m_cmd = $urandom % 16;
      cmd = m_cmd[3:0];
      wt("par", 0, m_cmd);
    end
    hold = 1'b1;
    repeat (4) @(negedge sys_clk);
    cmd = ~cmd;
    repeat (8) @(negedge sys_clk);
    wt("hold", 0, m_cmd);
    off_n = 1'b0;
    wt("off", 0, 0);
    off_n = 1'b1;
    hold = 1'b0;
    m_cmd = cmd;
    wt("open", 0, m_cmd);
    en = 1'b0;
    cmd = ~cmd;
    repeat (6) @(negedge sys_clk);
    chk("frozen", m_cmd, obs(0));
    en = 1'b1;
    m_cmd = cmd;
    wt("thaw", 0, m_cmd);
    chk("od", 0, {5'h00, f_o, r_o, e_o});
    $display("parallel done");
    for (int v = 1; v >= 0; v--) begin
      fast = v[0];
      wt("fast", 5, v);
    end
    cmd = 4'hf;
    wt("all on", 0, 15);
    for (int k = 0; k < 6; k++) begin
      mon = '0;
      case (k)
        0: mon.chip_hot = 1'b1;
        1: mon.v5_low = 1'b1;
        2: mon.limit_short = 1'b1;
        3: mon.ch_reverse = 4'h9;
        4: mon.ch_hot = 4'h4;
        default: mon.any_supply_low = 1'b1;
      endcase
      if (k < 5) wt("fault", 1, 1);
      if (k == 0 || k == 2 || k == 5) wt("shut", 0, 0);
      if (k == 4) wt("ch hot", 0, 11);
      wt("rev", 2, k == 3);
      mon = '0;
      wt("clear", 1, 0);
    end
    mon = '0;
    wt("clear", 1, 0);
    $display("fault done");
    cmd = 4'h0;
    boost = 1'b1;
    wt("low", 0, 0);
    cmd = 4'h2;
    wt("boost", 4, 1);
    repeat (BOOST - 1) @(negedge sys_clk);
    chk("boost hold", 1, obs(4));
    @(negedge sys_clk);
    chk("boost end", 0, obs(4));
    cmd = 4'h3;
    wt("boost again", 4, 1);
    boost = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk("boost off", 0, obs(4));
    $display("boost done");
    ser = 1'b1;
    mon.ch_reverse = 4'($urandom);
    mon.ch_hot = 4'($urandom);
    repeat (10) @(negedge sys_clk);
    host.xfer(8'hf0, 32, rd);
    chk("sdo", {mon.ch_hot, mon.ch_reverse}, rd);
    @(negedge sys_clk);
    mon = '0;
    for (int j = 0; j < 4; j++) q.push_back($urandom % 16);
    while (q.size() > 0) begin
      m_cmd = q.pop_front();
      host.xfer({~m_cmd[3:0], m_cmd[3:0]}, 32, rd);
      wt("ser", 0, m_cmd);
      wt("err clr", 3, 0);
      chk("sdo off", 0, {7'h00, sdo_oe});
    end
    host.xfer({m_cmd[3:0], m_cmd[3:0]}, 32, rd);
    wt("err", 3, 1);
    wt("kept", 0, m_cmd);
    $display("serial done");
    stop_test();
  end
endmodule
`default_nettype wire
